// File: hw/sacd_pkg.sv
// shared constants and types for the command header decoder
package sacd_pkg;

  localparam logic [7:0] CLA_APP = 8'hA0;

  // instruction bytes
  localparam logic [7:0] INS_SELECT = 8'hA4;
  localparam logic [7:0] INS_STATUS = 8'hF2;
  localparam logic [7:0] INS_READ_BIN = 8'hB0;
  localparam logic [7:0] INS_UPD_BIN = 8'hD6;
  localparam logic [7:0] INS_READ_REC = 8'hB2;
  localparam logic [7:0] INS_UPD_REC = 8'hDC;
  localparam logic [7:0] INS_SEEK = 8'hA2;
  localparam logic [7:0] INS_INCREASE = 8'h32;
  localparam logic [7:0] INS_INVALIDATE = 8'h04;
  localparam logic [7:0] INS_REHAB = 8'h44;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_CHANGE = 8'h24;
  localparam logic [7:0] INS_DISABLE = 8'h26;
  localparam logic [7:0] INS_ENABLE = 8'h28;
  localparam logic [7:0] INS_UNBLOCK = 8'h2C;
  localparam logic [7:0] INS_RUN_ALG = 8'h88;
  localparam logic [7:0] INS_SLEEP = 8'hFA;
  localparam logic [7:0] INS_GET_RSP = 8'hC0;
  localparam logic [7:0] INS_TERM_PROF = 8'h10;
  localparam logic [7:0] INS_ENVELOPE = 8'hC2;
  localparam logic [7:0] INS_FETCH = 8'h12;
  localparam logic [7:0] INS_TERM_RSP = 8'h14;

  // operational reserved group is 1X, X even 6..E
  localparam logic [3:0] OPS_RSV_HI = 4'h1;
  localparam logic [3:0] OPS_RSV_LO_MIN = 4'h6;
  localparam logic [3:0] OPS_RSV_LO_MAX = 4'hE;

  // secret code selection in unblock
  localparam logic [7:0] UNBLOCK_SEL_FIRST = 8'h00;
  localparam logic [7:0] UNBLOCK_SEL_SECOND = 8'h02;

  localparam logic [7:0] SELECT_P3 = 8'h02;
  localparam logic [8:0] LEN_ZERO_OUT = 9'h100;

  // directory select response layout
  localparam logic [7:0] DIR_RSP_LEN = 8'h22;
  localparam logic [7:0] DIR_APP_LEN = 8'h15;
  localparam logic [5:0] B_FREE_HI = 6'h03;
  localparam logic [5:0] B_FREE_LO = 6'h04;
  localparam logic [5:0] B_FID_HI = 6'h05;
  localparam logic [5:0] B_FID_LO = 6'h06;
  localparam logic [5:0] B_TYPE = 6'h07;
  localparam logic [5:0] B_APP_LEN = 6'h0D;
  localparam logic [5:0] B_APP_FIRST = 6'h0E;
  localparam logic [5:0] B_APP_LAST = 6'h22;
  localparam logic [7:0] RSV_BYTE = 8'h00;

  // status words
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW1_PENDING = 8'h9F;
  localparam logic [7:0] SW1_BAD_LEN = 8'h67;
  localparam logic [7:0] SW1_BAD_INS = 8'h6D;
  localparam logic [7:0] SW1_NO_DATA = 8'h6F;
  localparam logic [7:0] SW2_NONE = 8'h00;

  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_IN = 2'b01,
    DIR_OUT = 2'b10,
    DIR_BOTH = 2'b11
  } sacd_dir_t;

  typedef enum logic [4:0] {
    FN_NONE = 5'h00,
    FN_SELECT = 5'h01,
    FN_STATUS = 5'h02,
    FN_READ_BIN = 5'h03,
    FN_UPD_BIN = 5'h04,
    FN_READ_REC = 5'h05,
    FN_UPD_REC = 5'h06,
    FN_SEEK = 5'h07,
    FN_INCREASE = 5'h08,
    FN_INVALIDATE = 5'h09,
    FN_REHAB = 5'h0A,
    FN_VERIFY = 5'h0B,
    FN_CHANGE = 5'h0C,
    FN_DISABLE = 5'h0D,
    FN_ENABLE = 5'h0E,
    FN_UNBLOCK = 5'h0F,
    FN_RUN_ALG = 5'h10,
    FN_SLEEP = 5'h11,
    FN_GET_RSP = 5'h12,
    FN_TERM_PROF = 5'h13,
    FN_ENVELOPE = 5'h14,
    FN_FETCH = 5'h15,
    FN_TERM_RSP = 5'h16,
    FN_RSV_OPS = 5'h1E,
    FN_RSV_ADM = 5'h1F
  } sacd_fn_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEL_DATA = 2'b01,
    ST_RSP_OUT = 2'b10
  } sacd_state_t;

endpackage

// File: hw/sacd_dir_rsp.sv
// byte formatter for the directory select response
`timescale 1ns/1ns
module sacd_dir_rsp (
  input wire logic [5:0] i_idx,
  input wire logic [15:0] i_free_mem,
  input wire logic [15:0] i_file_id,
  input wire logic [7:0] i_file_type,
  input wire logic [7:0] i_app_byte,
  output logic [7:0] o_byte
);

  always_comb
  begin
    o_byte = sacd_pkg::RSV_BYTE;
    if (i_idx == sacd_pkg::B_FREE_HI)
    begin
      o_byte = i_free_mem[15:8];
    end
    else if (i_idx == sacd_pkg::B_FREE_LO)
    begin
      o_byte = i_free_mem[7:0];
    end
    else if (i_idx == sacd_pkg::B_FID_HI)
    begin
      o_byte = i_file_id[15:8];
    end
    else if (i_idx == sacd_pkg::B_FID_LO)
    begin
      o_byte = i_file_id[7:0];
    end
    else if (i_idx == sacd_pkg::B_TYPE)
    begin
      o_byte = i_file_type;
    end
    else if (i_idx == sacd_pkg::B_APP_LEN)
    begin
      o_byte = sacd_pkg::DIR_APP_LEN;
    end
    else if (i_idx >= sacd_pkg::B_APP_FIRST && i_idx <= sacd_pkg::B_APP_LAST)
    begin
      o_byte = i_app_byte;
    end
  end

endmodule

// File: hw/sacd_top.sv
// card-side command header decoder with select and get-response handling
// What this block does
// - binary read/update offset: first parameter high byte, second low byte.
// - offset zero starts at first body byte, one at the second.
// - every command has a fixed data direction both sides follow.
// - codes 1X with X even from 6 to E are reserved, never decoded.
// - listed administrative codes are reserved, not operational commands.
// - file commands decode from their fixed instruction bytes.
// - security and toolkit commands decode from their fixed instruction bytes.
// - unblock second parameter 00 picks first secret code, 02 the second.
// - directory response: reserved, free memory, identifier, type, reserved bytes.
// - bytes 3-4 report unallocated memory of the selected directory.
// - byte 13 gives following length; bytes 14-34 hold 21 application bytes.
// - select uses parameters 00 00 02 and a two-byte file identifier.
// - only class A0 commands act; others leave state unchanged.
// - length zero means 256 bytes outgoing and nothing incoming.
// - pending output answers 9F plus length; get response fetches it.
`timescale 1ns/1ns
module sacd_top (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_HDR_VALID,
  input wire logic [7:0] I_CLA,
  input wire logic [7:0] I_INS,
  input wire logic [7:0] I_P1,
  input wire logic [7:0] I_P2,
  input wire logic [7:0] I_P3,
  input wire logic I_DATA_VALID,
  input wire logic [7:0] I_DATA,
  input wire logic [15:0] I_FREE_MEM,
  input wire logic [7:0] I_FILE_TYPE,
  input wire logic [7:0] I_APP_BYTE,
  output logic O_CMD_VALID,
  output logic [4:0] O_CMD_FN,
  output logic [1:0] O_CMD_DIR,
  output logic [15:0] O_OFFSET,
  output logic [7:0] O_REC_NO,
  output logic [7:0] O_MODE,
  output logic [8:0] O_XFER_LEN,
  output logic O_SECRET_SEL,
  output logic O_FOREIGN,
  output logic O_SW_VALID,
  output logic [7:0] O_SW1,
  output logic [7:0] O_SW2,
  output logic O_RSP_VALID,
  output logic [7:0] O_RSP_BYTE,
  output logic [5:0] O_APP_IDX,
  output logic [15:0] O_SEL_FID
);

  function automatic sacd_pkg::sacd_fn_t decode_ins(input logic [7:0] ins);
    sacd_pkg::sacd_fn_t fn;
    fn = sacd_pkg::FN_NONE;
    case (ins)
      sacd_pkg::INS_SELECT: fn = sacd_pkg::FN_SELECT;
      sacd_pkg::INS_STATUS: fn = sacd_pkg::FN_STATUS;
      sacd_pkg::INS_READ_BIN: fn = sacd_pkg::FN_READ_BIN;
      sacd_pkg::INS_UPD_BIN: fn = sacd_pkg::FN_UPD_BIN;
      sacd_pkg::INS_READ_REC: fn = sacd_pkg::FN_READ_REC;
      sacd_pkg::INS_UPD_REC: fn = sacd_pkg::FN_UPD_REC;
      sacd_pkg::INS_SEEK: fn = sacd_pkg::FN_SEEK;
      sacd_pkg::INS_INCREASE: fn = sacd_pkg::FN_INCREASE;
      sacd_pkg::INS_INVALIDATE: fn = sacd_pkg::FN_INVALIDATE;
      sacd_pkg::INS_REHAB: fn = sacd_pkg::FN_REHAB;
      sacd_pkg::INS_VERIFY: fn = sacd_pkg::FN_VERIFY;
      sacd_pkg::INS_CHANGE: fn = sacd_pkg::FN_CHANGE;
      sacd_pkg::INS_DISABLE: fn = sacd_pkg::FN_DISABLE;
      sacd_pkg::INS_ENABLE: fn = sacd_pkg::FN_ENABLE;
      sacd_pkg::INS_UNBLOCK: fn = sacd_pkg::FN_UNBLOCK;
      sacd_pkg::INS_RUN_ALG: fn = sacd_pkg::FN_RUN_ALG;
      sacd_pkg::INS_SLEEP: fn = sacd_pkg::FN_SLEEP;
      sacd_pkg::INS_GET_RSP: fn = sacd_pkg::FN_GET_RSP;
      sacd_pkg::INS_TERM_PROF: fn = sacd_pkg::FN_TERM_PROF;
      sacd_pkg::INS_ENVELOPE: fn = sacd_pkg::FN_ENVELOPE;
      sacd_pkg::INS_FETCH: fn = sacd_pkg::FN_FETCH;
      sacd_pkg::INS_TERM_RSP: fn = sacd_pkg::FN_TERM_RSP;
      8'h2A, 8'hD0, 8'hD2, 8'hDE, 8'hC4, 8'hC6, 8'hC8,
      8'hCA, 8'hCC, 8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC:
        fn = sacd_pkg::FN_RSV_ADM;
      default:
      begin
        if (ins[7:4] == sacd_pkg::OPS_RSV_HI && !ins[0] &&
            ins[3:0] >= sacd_pkg::OPS_RSV_LO_MIN && ins[3:0] <= sacd_pkg::OPS_RSV_LO_MAX)
        begin
          fn = sacd_pkg::FN_RSV_OPS;
        end
      end
    endcase
    return fn;
  endfunction

  function automatic sacd_pkg::sacd_dir_t fn_dir(input sacd_pkg::sacd_fn_t fn);
    sacd_pkg::sacd_dir_t d;
    d = sacd_pkg::DIR_NONE;
    case (fn)
      sacd_pkg::FN_STATUS, sacd_pkg::FN_READ_BIN, sacd_pkg::FN_READ_REC,
      sacd_pkg::FN_GET_RSP, sacd_pkg::FN_FETCH:
        d = sacd_pkg::DIR_OUT;
      sacd_pkg::FN_UPD_BIN, sacd_pkg::FN_UPD_REC, sacd_pkg::FN_VERIFY,
      sacd_pkg::FN_CHANGE, sacd_pkg::FN_DISABLE, sacd_pkg::FN_ENABLE,
      sacd_pkg::FN_UNBLOCK, sacd_pkg::FN_TERM_PROF, sacd_pkg::FN_TERM_RSP:
        d = sacd_pkg::DIR_IN;
      sacd_pkg::FN_SELECT, sacd_pkg::FN_SEEK, sacd_pkg::FN_INCREASE,
      sacd_pkg::FN_RUN_ALG, sacd_pkg::FN_ENVELOPE:
        d = sacd_pkg::DIR_BOTH;
      default:
        d = sacd_pkg::DIR_NONE;
    endcase
    return d;
  endfunction

  sacd_pkg::sacd_state_t state_q;
  sacd_pkg::sacd_fn_t hdr_fn;
  sacd_pkg::sacd_dir_t hdr_dir;
  logic app_cmd;
  logic [8:0] hdr_len;
  logic [15:0] sel_fid_q;
  logic [15:0] fid_shift_q;
  logic fid_half_q;
  logic [7:0] pending_q;
  logic [8:0] out_left_q;
  logic [5:0] out_idx_q;
  logic [7:0] fmt_byte;

  assign hdr_fn = decode_ins(I_INS);
  assign hdr_dir = fn_dir(hdr_fn);
  // foreign class headers are ignored while a select or response is in progress too
  assign app_cmd = I_HDR_VALID && state_q == sacd_pkg::ST_IDLE && I_CLA == sacd_pkg::CLA_APP;
  // zero only means 256 when the card sends
  assign hdr_len = (I_P3 == 8'h00 && hdr_dir == sacd_pkg::DIR_OUT) ?
                   sacd_pkg::LEN_ZERO_OUT : {1'b0, I_P3};

  sacd_dir_rsp u_fmt (
    .i_idx(out_idx_q),
    .i_free_mem(I_FREE_MEM),
    .i_file_id(sel_fid_q),
    .i_file_type(I_FILE_TYPE),
    .i_app_byte(I_APP_BYTE),
    .o_byte(fmt_byte)
  );

  assign O_APP_IDX = out_idx_q;
  assign O_SEL_FID = sel_fid_q;

  // decoded header fields
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      O_CMD_VALID <= 1'b0;
      O_CMD_FN <= 5'h00;
      O_CMD_DIR <= 2'h0;
      O_OFFSET <= 16'h0000;
      O_REC_NO <= 8'h00;
      O_MODE <= 8'h00;
      O_XFER_LEN <= 9'h000;
      O_SECRET_SEL <= 1'b0;
      O_FOREIGN <= 1'b0;
    end
    else
    begin
      O_FOREIGN <= I_HDR_VALID && state_q == sacd_pkg::ST_IDLE &&
                   I_CLA != sacd_pkg::CLA_APP;
      O_CMD_VALID <= app_cmd && hdr_fn != sacd_pkg::FN_NONE &&
                     hdr_fn != sacd_pkg::FN_RSV_OPS && hdr_fn != sacd_pkg::FN_RSV_ADM;
      if (app_cmd)
      begin
        O_CMD_FN <= hdr_fn;
        O_CMD_DIR <= hdr_dir;
        // offset counts from the first body byte, so zero means no skip
        O_OFFSET <= {I_P1, I_P2};
        O_REC_NO <= I_P1;
        O_MODE <= I_P2;
        O_XFER_LEN <= hdr_len;
        O_SECRET_SEL <= (hdr_fn == sacd_pkg::FN_UNBLOCK) &&
                        (I_P2 == sacd_pkg::UNBLOCK_SEL_SECOND);
      end
    end
  end

  // command sequencing, status words and response stream
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      state_q <= sacd_pkg::ST_IDLE;
      sel_fid_q <= 16'h0000;
      fid_shift_q <= 16'h0000;
      fid_half_q <= 1'b0;
      pending_q <= 8'h00;
      out_left_q <= 9'h000;
      out_idx_q <= 6'h00;
      O_SW_VALID <= 1'b0;
      O_SW1 <= 8'h00;
      O_SW2 <= 8'h00;
      O_RSP_VALID <= 1'b0;
      O_RSP_BYTE <= 8'h00;
    end
    else
    begin
      O_SW_VALID <= 1'b0;
      O_RSP_VALID <= 1'b0;
      case (state_q)
        sacd_pkg::ST_IDLE:
        begin
          if (app_cmd)
          begin
            if (hdr_fn == sacd_pkg::FN_NONE || hdr_fn == sacd_pkg::FN_RSV_OPS ||
                hdr_fn == sacd_pkg::FN_RSV_ADM)
            begin
              O_SW_VALID <= 1'b1;
              O_SW1 <= sacd_pkg::SW1_BAD_INS;
              O_SW2 <= sacd_pkg::SW2_NONE;
            end
            else if (hdr_fn == sacd_pkg::FN_SELECT)
            begin
              if (I_P1 == 8'h00 && I_P2 == 8'h00 && I_P3 == sacd_pkg::SELECT_P3)
              begin
                fid_half_q <= 1'b0;
                state_q <= sacd_pkg::ST_SEL_DATA;
              end
              else
              begin
                O_SW_VALID <= 1'b1;
                O_SW1 <= sacd_pkg::SW1_BAD_LEN;
                O_SW2 <= sacd_pkg::SW2_NONE;
              end
            end
            else if (hdr_fn == sacd_pkg::FN_GET_RSP)
            begin
              if (pending_q == 8'h00)
              begin
                O_SW_VALID <= 1'b1;
                O_SW1 <= sacd_pkg::SW1_NO_DATA;
                O_SW2 <= sacd_pkg::SW2_NONE;
              end
              else if (hdr_len > {1'b0, pending_q})
              begin
                O_SW_VALID <= 1'b1;
                O_SW1 <= sacd_pkg::SW1_BAD_LEN;
                O_SW2 <= pending_q;
              end
              else
              begin
                out_left_q <= hdr_len;
                out_idx_q <= 6'h01;
                state_q <= sacd_pkg::ST_RSP_OUT;
              end
            end
          end
        end
        sacd_pkg::ST_SEL_DATA:
        begin
          if (I_DATA_VALID)
          begin
            fid_shift_q <= {fid_shift_q[7:0], I_DATA};
            fid_half_q <= 1'b1;
            if (fid_half_q)
            begin
              sel_fid_q <= {fid_shift_q[7:0], I_DATA};
              pending_q <= sacd_pkg::DIR_RSP_LEN;
              O_SW_VALID <= 1'b1;
              O_SW1 <= sacd_pkg::SW1_PENDING;
              O_SW2 <= sacd_pkg::DIR_RSP_LEN;
              state_q <= sacd_pkg::ST_IDLE;
            end
          end
        end
        sacd_pkg::ST_RSP_OUT:
        begin
          O_RSP_VALID <= 1'b1;
          O_RSP_BYTE <= fmt_byte;
          out_idx_q <= out_idx_q + 6'h01;
          out_left_q <= out_left_q - 9'h001;
          if (out_left_q == 9'h001)
          begin
            pending_q <= 8'h00;
            out_idx_q <= 6'h00;
            O_SW_VALID <= 1'b1;
            O_SW1 <= sacd_pkg::SW1_OK;
            O_SW2 <= sacd_pkg::SW2_NONE;
            state_q <= sacd_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= sacd_pkg::ST_IDLE;
      endcase
    end
  end

endmodule

// File: sim/sacd_top_asserts.sv
// port-level assertions for the command header decoder
`timescale 1ns/1ns
module sacd_top_asserts (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_HDR_VALID,
  input wire logic [7:0] I_CLA,
  input wire logic [7:0] I_INS,
  input wire logic [7:0] I_P1,
  input wire logic [7:0] I_P2,
  input wire logic [7:0] I_P3,
  input wire logic I_DATA_VALID,
  input wire logic O_CMD_VALID,
  input wire logic [4:0] O_CMD_FN,
  input wire logic [1:0] O_CMD_DIR,
  input wire logic [15:0] O_OFFSET,
  input wire logic [8:0] O_XFER_LEN,
  input wire logic O_SECRET_SEL,
  input wire logic O_FOREIGN,
  input wire logic O_SW_VALID,
  input wire logic [7:0] O_SW1,
  input wire logic [7:0] O_SW2,
  input wire logic O_RSP_VALID,
  input wire logic [7:0] O_RSP_BYTE,
  input wire logic [5:0] O_APP_IDX
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  sequence s_admin_hdr;
    I_HDR_VALID && I_CLA == 8'hA0 && I_INS == 8'h2A;
  endsequence
  sequence s_refuse;
    O_SW_VALID && !O_CMD_VALID && O_SW1 == 8'h6D && O_SW2 == 8'h00;
  endsequence
  sequence s_sel_hdr;
    I_HDR_VALID && I_CLA == 8'hA0 && I_INS == 8'hA4 && {I_P1, I_P2, I_P3} == 24'h000002;
  endsequence
  property p_foreign;
    O_FOREIGN |-> $past(I_HDR_VALID) && $past(I_CLA) != 8'hA0 && !O_CMD_VALID;
  endproperty
  property p_offset;
    O_CMD_VALID |-> $past(I_CLA) == 8'hA0 && O_OFFSET == {$past(I_P1), $past(I_P2)};
  endproperty
  property p_ops_rsv;
    O_CMD_VALID |-> !($past(I_INS[7:4]) == 4'h1 && !$past(I_INS[0]) && $past(I_INS[3:0]) > 4'h5);
  endproperty
  property p_admin;
    s_admin_hdr |=> s_refuse;
  endproperty
  property p_secret;
    O_CMD_VALID |-> O_SECRET_SEL == ($past(I_INS) == 8'h2C && $past(I_P2) == 8'h02);
  endproperty
  property p_len;
    O_CMD_VALID |-> O_XFER_LEN == (($past(I_P3) == 8'h00 && O_CMD_DIR == 2'b10) ? 9'h100
      : {1'b0, $past(I_P3)});
  endproperty
  property p_dir;
    O_CMD_VALID && O_CMD_FN == 5'h03 |-> O_CMD_DIR == 2'b10;
  endproperty
  property p_len_byte;
    O_RSP_VALID && $past(O_APP_IDX) == 6'h0D |-> O_RSP_BYTE == 8'h15;
  endproperty
  property p_pending;
    O_SW_VALID && O_SW1 == 8'h9F |-> O_SW2 == 8'h22 && $past(I_DATA_VALID);
  endproperty
  property p_sel;
    s_sel_hdr |=> O_CMD_VALID && O_CMD_FN == 5'h01 ##1 !O_SW_VALID [*2];
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign class misflagged");
  a_offset: assert property (p_offset) else $error("offset bytes misplaced");
  a_ops_rsv: assert property (p_ops_rsv) else $error("reserved code decoded");
  a_admin: assert property (p_admin) else $error("admin code not refused");
  a_secret: assert property (p_secret) else $error("secret code select wrong");
  a_len: assert property (p_len) else $error("transfer length wrong");
  a_dir: assert property (p_dir) else $error("read direction wrong");
  a_len_byte: assert property (p_len_byte) else $error("length byte wrong");
  a_pending: assert property (p_pending) else $error("pending status wrong");
  a_sel: assert property (p_sel) else $error("select decode wrong");
endmodule
bind sacd_top sacd_top_asserts sacd_top_asserts_i (.I_CLK, .I_SYS_RST, .I_HDR_VALID, .I_CLA,
  .I_INS, .I_P1, .I_P2, .I_P3, .I_DATA_VALID, .O_CMD_VALID, .O_CMD_FN, .O_CMD_DIR, .O_OFFSET,
  .O_XFER_LEN, .O_SECRET_SEL, .O_FOREIGN, .O_SW_VALID, .O_SW1, .O_SW2, .O_RSP_VALID,
  .O_RSP_BYTE, .O_APP_IDX);

// File: sim/sacd_term_model.sv
// terminal-side model issuing command headers and command data bytes
`timescale 1ns/1ns
module sacd_term_model (
  input wire logic clk,
  output logic hdr_valid,
  output logic [7:0] cla,
  output logic [7:0] ins,
  output logic [7:0] p1,
  output logic [7:0] p2,
  output logic [7:0] p3,
  output logic data_valid,
  output logic [7:0] data
);
  initial
  begin
    hdr_valid = 1'b0;
    {cla, ins, p1, p2, p3} = 40'h0;
    data_valid = 1'b0;
    data = 8'h00;
  end
  // fields inverted after release so a stale header never looks current
  task automatic send_hdr(input logic [7:0] c, i, a, b, n);
    @(posedge clk) #1;
    hdr_valid = 1'b1;
    {cla, ins, p1, p2, p3} = {c, i, a, b, n};
    @(posedge clk) #1;
    hdr_valid = 1'b0;
    {cla, ins, p1, p2, p3} = ~{c, i, a, b, n};
  endtask
  task automatic send_data(input logic [7:0] d);
    @(posedge clk) #1;
    data_valid = 1'b1;
    data = d;
    @(posedge clk) #1;
    data_valid = 1'b0;
    data = ~d;
  endtask
endmodule

// File: sim/sacd_top_test.sv
// self-checking bench for the command header decoder
`timescale 1ns/1ns
module sacd_top_test;
  logic I_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic I_HDR_VALID, I_DATA_VALID, O_CMD_VALID, O_SECRET_SEL, O_FOREIGN, O_SW_VALID, O_RSP_VALID;
  logic [7:0] I_CLA, I_INS, I_P1, I_P2, I_P3, I_DATA, I_FILE_TYPE, I_APP_BYTE, O_REC_NO, O_MODE;
  logic [7:0] O_SW1, O_SW2, O_RSP_BYTE, p3;
  logic [15:0] I_FREE_MEM, O_OFFSET, O_SEL_FID, fid;
  logic [4:0] O_CMD_FN;
  logic [1:0] O_CMD_DIR;
  logic [8:0] O_XFER_LEN;
  logic [5:0] O_APP_IDX;
  logic [31:0] seed;
  logic [7:0] ins_tab [22] = '{8'hA4, 8'hF2, 8'hB0, 8'hD6, 8'hB2, 8'hDC, 8'hA2, 8'h32, 8'h04,
    8'h44, 8'h20, 8'h24, 8'h26, 8'h28, 8'h2C, 8'h88, 8'hFA, 8'hC0, 8'h10, 8'hC2, 8'h12, 8'h14};
  logic [1:0] dir_tab [22] = '{3, 2, 2, 1, 2, 1, 3, 3, 0, 0, 1, 1, 1, 1, 1, 3, 0, 2, 1, 3, 2, 1};
  // undefined 00 and FF ride along with the reserved codes
  logic [7:0] rsv_tab [21] = '{8'h16, 8'h18, 8'h1A, 8'h1C, 8'h1E, 8'h2A, 8'hD0, 8'hD2, 8'hDE,
    8'hC4, 8'hC6, 8'hC8, 8'hCA, 8'hCC, 8'hB4, 8'hB6, 8'hB8, 8'hBA, 8'hBC, 8'h00, 8'hFF};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  assign I_APP_BYTE = {2'b10, O_APP_IDX} ^ 8'h5A;
  always #5 I_CLK = ~I_CLK;
  sacd_top sacd_top_i (.I_CLK, .I_SYS_RST, .I_HDR_VALID, .I_CLA, .I_INS, .I_P1, .I_P2, .I_P3,
    .I_DATA_VALID, .I_DATA, .I_FREE_MEM, .I_FILE_TYPE, .I_APP_BYTE, .O_CMD_VALID, .O_CMD_FN,
    .O_CMD_DIR, .O_OFFSET, .O_REC_NO, .O_MODE, .O_XFER_LEN, .O_SECRET_SEL, .O_FOREIGN,
    .O_SW_VALID, .O_SW1, .O_SW2, .O_RSP_VALID, .O_RSP_BYTE, .O_APP_IDX, .O_SEL_FID);
  sacd_term_model sacd_term_model_i (.clk(I_CLK), .hdr_valid(I_HDR_VALID), .cla(I_CLA),
    .ins(I_INS), .p1(I_P1), .p2(I_P2), .p3(I_P3), .data_valid(I_DATA_VALID), .data(I_DATA));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_rsp(input logic [5:0] k);
    case (k)
      6'd3: return I_FREE_MEM[15:8];
      6'd4: return I_FREE_MEM[7:0];
      6'd5: return fid[15:8];
      6'd6: return fid[7:0];
      6'd7: return I_FILE_TYPE;
      6'd13: return 8'h15;
      default: return (k > 6'd13) ? {2'b10, k} ^ 8'h5A : 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hdr(input logic [7:0] i, a, b, n);
    sacd_term_model_i.send_hdr(8'hA0, i, a, b, n);
  endtask
  always @(posedge I_CLK)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      give_verdict();
    end
  end
  initial
  begin
    seed = 32'h3A673106;
    I_FREE_MEM = seed[15:0];
    I_FILE_TYPE = seed[23:16];
    repeat (10) @(posedge I_CLK);
    #1 I_SYS_RST = 1'b0;
    for (int i = 0; i < 22; i++)
    begin
      seed = lfsr(seed);
      p3 = (i == 2 || i == 3) ? 8'h00 : (i == 0) ? 8'h01 : seed[23:16];
      hdr(ins_tab[i], seed[7:0], seed[15:8], p3);
      chk(O_CMD_VALID, 1);
      chk(O_CMD_FN, i + 1);
      chk(O_CMD_DIR, dir_tab[i]);
      chk(O_OFFSET, {seed[7:0], seed[15:8]});
      chk({O_REC_NO, O_MODE}, {seed[7:0], seed[15:8]});
      chk(O_XFER_LEN, (p3 == 8'h00 && dir_tab[i] == 2'd2) ? 9'h100 : {1'b0, p3});
      if (i == 0)
        chk({O_SW1, O_SW2}, 16'h6700);
    end
    foreach (rsv_tab[i])
    begin
      seed = lfsr(seed);
      hdr(rsv_tab[i], seed[7:0], seed[15:8], seed[23:16]);
      chk({O_CMD_VALID, O_SW_VALID}, 2'b01);
      chk({O_SW1, O_SW2}, 16'h6D00);
    end
    hdr(8'hB0, 8'h00, 8'h01, 8'h04);
    chk(O_OFFSET, 16'h0001);
    sacd_term_model_i.send_hdr(8'hA1, 8'hB0, 8'h12, 8'h34, 8'h04);
    chk({O_FOREIGN, O_CMD_VALID, O_OFFSET}, {2'b10, 16'h0001});
    for (int k = 0; k < 3; k++)
    begin
      hdr(8'h2C, 8'h00, k[7:0], 8'h10);
      chk(O_SECRET_SEL, k == 2);
    end
    fid = seed[31:16];
    hdr(8'hA4, 8'h00, 8'h00, 8'h02);
    chk({O_CMD_VALID, O_CMD_FN}, 6'h21);
    sacd_term_model_i.send_data(fid[15:8]);
    repeat (2) @(posedge I_CLK);
    sacd_term_model_i.send_data(fid[7:0]);
    chk({O_SW_VALID, O_SW1, O_SW2}, 17'h19F22);
    chk(O_SEL_FID, fid);
    // asking for more than is pending is refused and keeps the pending data
    hdr(8'hC0, 8'h00, 8'h00, 8'h23);
    chk({O_SW_VALID, O_SW1, O_SW2}, 17'h16722);
    hdr(8'hC0, 8'h00, 8'h00, 8'h22);
    chk(O_APP_IDX, 1);
    for (int k = 1; k <= 34; k++)
    begin
      @(posedge I_CLK) #1;
      chk({O_RSP_VALID, O_RSP_BYTE}, {1'b1, exp_rsp(k[5:0])});
      chk(O_SW_VALID, k == 34);
    end
    chk({O_SW1, O_SW2}, 16'h9000);
    hdr(8'hC0, 8'h00, 8'h00, 8'h05);
    chk({O_SW_VALID, O_SW1, O_SW2}, 17'h16F00);
    give_verdict();
  end
endmodule
